// [src/mre_pkg.sv]
/*
 * Shared constants for the multi-panel row erase serial port:
 * command codes, core instruction payloads, register offsets, timing.
 * Assumes both ends import it; no logic here.
 */
package mre_pkg;
    localparam int CMD_W = 4;
    localparam int OPND_W = 16;
    localparam int INSTR_W = 20;
    localparam int ADDR_W = 22;
    localparam int ROW_BYTES = 64;

    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_TWRITE = 4'hC;
    localparam logic [3:0] CMD_TWRITE_START = 4'hF;

    localparam logic [21:0] PROG_CTRL_ADDR = 22'h3C_0006;
    localparam logic [7:0] PROG_CTRL_MULTI = 8'h40;
    localparam logic [7:0] PROG_CTRL_RESET = 8'h00;

    // core instruction payloads (opcode high byte, file low byte)
    localparam logic [15:0] OP_SET_PMSEL = 16'h8EA6;
    localparam logic [15:0] OP_SET_CFGSEL = 16'h8CA6;
    localparam logic [15:0] OP_SET_WPERMIT = 16'h86A6;
    localparam logic [15:0] OP_CLR_CFGSEL = 16'h9CA6;
    localparam logic [15:0] OP_SET_ROWERASE = 16'h88A6;
    localparam logic [15:0] OP_NOP = 16'h0000;
    localparam logic [7:0] OPC_MOVLW = 8'h0E;
    localparam logic [7:0] OPC_MOVWF = 8'h6E;
    localparam logic [7:0] OPC_CLRF = 8'h6A;
    localparam logic [7:0] REG_PTR_UPPER = 8'hF8;
    localparam logic [7:0] REG_PTR_HIGH = 8'hF7;
    localparam logic [7:0] REG_PTR_LOW = 8'hF6;
    localparam logic [7:0] REG_MEMCTRL = 8'hA6;

    // memory control bit positions
    localparam int MC_PMSEL = 7;
    localparam int MC_CFGSEL = 6;
    localparam int MC_ROWERASE = 4;
    // the bit that the set-write-permit payload addresses
    localparam int MC_WPERMIT = 3;

    // erase pulse and discharge, ns, and host-side counts at sys_clk
    localparam int SYS_CLK_NS = 8;
    localparam int ERASE_PULSE_NS = 1000;
    localparam int DISCHARGE_NS = 200;
    localparam int ERASE_PULSE_CYC = (ERASE_PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int DISCHARGE_CYC = (DISCHARGE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int SCLK_HALF_CYC = 2;
endpackage : mre_pkg

// [src/mre_link_if.sv]
/*
 * Serial programming link: link clock and data pin as six signals.
 * Assumes the host drives the clock; data is shared, resolved here.
 */
`timescale 1ns/10ps
`default_nettype none
interface mre_link_if;
    logic progClk;
    logic dataHostOut;
    logic dataHostOe;
    logic dataDevOut;
    logic dataDevOe;
    wire logic progDataPin;

    assign progDataPin = dataHostOe ? dataHostOut : (dataDevOe ? dataDevOut : 1'b0);

    modport host (output progClk, output dataHostOut, output dataHostOe, input progDataPin);
    modport dev (input progClk, output dataDevOut, output dataDevOe, input progDataPin);
endinterface : mre_link_if
`default_nettype wire

// [src/mre_device.sv]
/*
 * Device end: shifts 20-bit instructions on the link clock, runs the
 * pointer, memory control and programming control, and raises the
 * erase pulse. The user side sees the row erase on sys_clk.
 * Assumes the host keeps the link protocol; link clock may stop.
 */
// Functional notes
// - one erase clears same row all panels
// - table write 40h at 3C0006h enables multi-panel
// - pulse lasts while fourth NOP clock high
// - pulse ends on clock fall; host discharges
// - host keeps pointer offset unchanged at start
// - host sets memory select, config, write permit
// - host clears config, sets row erase, clears pointer
// - host issues start command then NOP
// - host steps pointer by 64 per row
// - LSb first, driven rise, sampled fall
// - instruction is 4-bit command plus 16-bit operand
// - pointer built from upper, high, low bytes
`timescale 1ns/10ps
`default_nettype none
module mre_device
    import mre_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    mre_link_if.dev link,
    output logic erasePulse,
    output logic [21:0] eraseRowAddr,
    output logic multiPanelEn,
    output logic [7:0] memCtrlState,
    output logic eraseDone
);
    import mre_pkg::*;

    logic [19:0] shift_r;
    logic [4:0] bitCnt_r;
    logic [7:0] wreg_r;
    logic [5:0] ptrUpper_r;
    logic [7:0] ptrHigh_r;
    logic [7:0] ptrLow_r;
    logic [7:0] memCtrl_r;
    logic [7:0] progCtrl_r;
    logic armed_r;
    logic pulse_r;
    logic [21:0] table_address_pointer;
    logic [19:0] instr;

    assign table_address_pointer = {ptrUpper_r, ptrHigh_r, ptrLow_r};
    assign instr = {link.progDataPin, shift_r[19:1]};
    assign link.dataDevOut = 1'b0;
    assign link.dataDevOe = 1'b0;

    // bits taken on falling link clock, lsb first, 20 per instruction
    always_ff @(negedge link.progClk or posedge rst)
    begin
        if (rst)
        begin
            shift_r <= 20'h0_0000;
            bitCnt_r <= 5'h00;
        end
        else
        begin
            shift_r <= instr;
            bitCnt_r <= (bitCnt_r == 5'(INSTR_W - 1)) ? 5'h00 : bitCnt_r + 5'h01;
        end
    end

    // MOVWF copies the working register, CLRF writes zero
    function automatic logic [7:0] ptrByteValue(
        input logic [7:0] opc,
        input logic [7:0] w
    );
        ptrByteValue = (opc == OPC_MOVWF) ? w : 8'h00;
    endfunction : ptrByteValue

    // core word that writes the given file register by MOVWF or CLRF
    function automatic logic writesFile(
        input logic [19:0] word,
        input logic [7:0] file
    );
        writesFile = word[3:0] == CMD_CORE && word[11:4] == file
            && (word[19:12] == OPC_MOVWF || word[19:12] == OPC_CLRF);
    endfunction : writesFile

    // instructions execute on the twentieth falling edge
    logic execNow;
    assign execNow = bitCnt_r == 5'(INSTR_W - 1);

    // working register: only MOVLW loads it
    always_ff @(negedge link.progClk or posedge rst)
    begin
        if (rst)
            wreg_r <= 8'h00;
        else if (execNow && instr[3:0] == CMD_CORE && instr[19:12] == OPC_MOVLW)
            wreg_r <= instr[11:4];
    end

    // pointer bytes; the upper byte keeps only its six address bits
    always_ff @(negedge link.progClk or posedge rst)
    begin
        if (rst)
        begin
            ptrUpper_r <= 6'h00;
            ptrHigh_r <= 8'h00;
            ptrLow_r <= 8'h00;
        end
        else if (execNow)
        begin
            if (writesFile(instr, REG_PTR_UPPER))
                ptrUpper_r <= 6'(ptrByteValue(instr[19:12], wreg_r));
            if (writesFile(instr, REG_PTR_HIGH))
                ptrHigh_r <= ptrByteValue(instr[19:12], wreg_r);
            if (writesFile(instr, REG_PTR_LOW))
                ptrLow_r <= ptrByteValue(instr[19:12], wreg_r);
        end
    end

    // memory control: 8x sets, 9x clears, bit number in [15:13]
    always_ff @(negedge link.progClk or posedge rst)
    begin
        if (rst)
            memCtrl_r <= 8'h00;
        else if (execNow && instr[3:0] == CMD_CORE && instr[11:4] == REG_MEMCTRL
            && instr[19:17] == 3'b100)
            memCtrl_r[instr[15:13]] <= ~instr[16];
    end

    // a table write elsewhere is ignored: no other table target here
    always_ff @(negedge link.progClk or posedge rst)
    begin
        if (rst)
            progCtrl_r <= PROG_CTRL_RESET;
        else if (execNow && instr[3:0] == CMD_TWRITE && table_address_pointer == PROG_CTRL_ADDR)
            progCtrl_r <= instr[11:4];
    end

    // any executed word but a start with write permit and row erase set disarms, so only the frame after a start can pulse
    always_ff @(negedge link.progClk or posedge rst)
    begin
        if (rst)
            armed_r <= 1'b0;
        else if (execNow)
            armed_r <= instr[3:0] == CMD_TWRITE_START
                && memCtrl_r[MC_WPERMIT] && memCtrl_r[MC_ROWERASE];
    end

    // pulse on while the fourth nop clock is high, off at its fall
    // bit 3 of that command is not taken yet at this rise, so it is not checked
    always_ff @(posedge link.progClk or negedge link.progClk or posedge rst)
    begin
        if (rst)
            pulse_r <= 1'b0;
        else
            pulse_r <= link.progClk && armed_r && bitCnt_r == 5'(CMD_W - 1)
                && shift_r[19:17] == 3'b000;
    end

    // sys_clk side: two-flop crossing of level state
    logic [1:0] pulseSync_r;
    logic [1:0] multiSync_r;
    logic pulseSeen_r;
    logic [7:0] memSync0_r;
    logic [7:0] memSync1_r;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pulseSync_r <= 2'b00;
            multiSync_r <= 2'b00;
            memSync0_r <= 8'h00;
            memSync1_r <= 8'h00;
        end
        else
        begin
            pulseSync_r <= {pulseSync_r[0], pulse_r};
            multiSync_r <= {multiSync_r[0], progCtrl_r == PROG_CTRL_MULTI};
            // one bit changes per instruction, so the word may cross on two flops
            memSync0_r <= memCtrl_r;
            memSync1_r <= memSync0_r;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            erasePulse <= 1'b0;
            multiPanelEn <= 1'b0;
            pulseSeen_r <= 1'b0;
            eraseDone <= 1'b0;
            eraseRowAddr <= 22'h00_0000;
            memCtrlState <= 8'h00;
        end
        else
        begin
            erasePulse <= pulseSync_r[1];
            multiPanelEn <= multiSync_r[1];
            pulseSeen_r <= pulseSync_r[1];
            eraseDone <= pulseSeen_r && !pulseSync_r[1];
            // pointer stable while pulse stands, so sampling it here is safe
            if (pulseSync_r[1] && !pulseSeen_r)
                eraseRowAddr <= {table_address_pointer[21:6], 6'h00};
            memCtrlState <= memSync1_r;
        end
    end
endmodule : mre_device
`default_nettype wire

// [src/mre_host.sv]
/*
 * Host end: programmer that sends the multi-panel row erase sequence
 * for a range of rows, timing pulse and discharge on sys_clk.
 * Assumes sys_clk 125 MHz; makes the link clock by a divider.
 */
`timescale 1ns/10ps
`default_nettype none
module mre_host
    import mre_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    mre_link_if.host link,
    input wire logic start,
    input wire logic [15:0] rowCount,
    output logic busy,
    output logic done
);
    import mre_pkg::*;

    typedef enum {H_IDLE, H_LOAD, H_SHIFT, H_PULSE, H_DISCH, H_NEXT} mre_hstate_t;
    mre_hstate_t state_r;
    logic [4:0] step_r;
    logic [19:0] word_r;
    logic [4:0] bitIdx_r;
    logic [7:0] half_r;
    logic [15:0] rows_r;
    logic [15:0] rowPtr_r;
    logic [9:0] tmr_r;
    logic clk_r;

    function automatic logic [19:0] core(input logic [15:0] op);
        core = {op, CMD_CORE};
    endfunction : core

    function automatic logic [19:0] seqWord(input logic [4:0] s, input logic [15:0] rp);
        unique case (s)
            5'd0: seqWord = core(OP_SET_PMSEL);
            5'd1: seqWord = core(OP_SET_CFGSEL);
            5'd2: seqWord = core(OP_SET_WPERMIT);
            5'd3: seqWord = core({OPC_MOVLW, 2'b00, PROG_CTRL_ADDR[21:16]});
            5'd4: seqWord = core({OPC_MOVWF, REG_PTR_UPPER});
            5'd5: seqWord = core({OPC_MOVLW, PROG_CTRL_ADDR[15:8]});
            5'd6: seqWord = core({OPC_MOVWF, REG_PTR_HIGH});
            5'd7: seqWord = core({OPC_MOVLW, PROG_CTRL_ADDR[7:0]});
            5'd8: seqWord = core({OPC_MOVWF, REG_PTR_LOW});
            5'd9: seqWord = {8'h00, PROG_CTRL_MULTI, CMD_TWRITE};
            5'd10: seqWord = core(OP_SET_PMSEL);
            5'd11: seqWord = core(OP_CLR_CFGSEL);
            5'd12: seqWord = core(OP_SET_ROWERASE);
            5'd13: seqWord = core({OPC_CLRF, REG_PTR_UPPER});
            5'd14: seqWord = core({OPC_CLRF, REG_PTR_HIGH});
            5'd15: seqWord = core({OPC_CLRF, REG_PTR_LOW});
            // row pointer: rp counts rows, address = rp*64
            5'd16: seqWord = core({OPC_MOVLW, 2'b00, rp[15:10]});
            5'd17: seqWord = core({OPC_MOVWF, REG_PTR_UPPER});
            5'd18: seqWord = core({OPC_MOVLW, rp[9:2]});
            5'd19: seqWord = core({OPC_MOVWF, REG_PTR_HIGH});
            5'd20: seqWord = core({OPC_MOVLW, rp[1:0], 6'h00});
            5'd21: seqWord = core({OPC_MOVWF, REG_PTR_LOW});
            5'd22: seqWord = {16'h0000, CMD_TWRITE_START};
            default: seqWord = core(OP_NOP);
        endcase
    endfunction : seqWord

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= H_IDLE;
            step_r <= 5'd0;
            word_r <= 20'h0_0000;
            bitIdx_r <= 5'd0;
            half_r <= 8'h00;
            rows_r <= 16'h0000;
            rowPtr_r <= 16'h0000;
            tmr_r <= 10'd0;
            clk_r <= 1'b0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            unique case (state_r)
                H_IDLE:
                    if (start && rowCount != 16'h0000)
                    begin
                        rows_r <= rowCount;
                        rowPtr_r <= 16'h0000;
                        step_r <= 5'd0;
                        busy <= 1'b1;
                        state_r <= H_LOAD;
                    end
                H_LOAD:
                begin
                    word_r <= seqWord(step_r, rowPtr_r);
                    bitIdx_r <= 5'd0;
                    half_r <= 8'h00;
                    state_r <= H_SHIFT;
                end
                H_SHIFT:
                begin
                    half_r <= half_r + 8'h01;
                    if (half_r == 8'(SCLK_HALF_CYC - 1))
                    begin
                        half_r <= 8'h00;
                        clk_r <= ~clk_r;
                        if (clk_r)
                        begin
                            // falling edge just made: the device has taken this bit
                            bitIdx_r <= bitIdx_r + 5'd1;
                            if (bitIdx_r == 5'(INSTR_W - 1))
                                state_r <= H_NEXT;
                        end
                        else
                        begin
                            // next bit leaves on the rise, clear of the sampling fall
                            if (bitIdx_r != 5'd0)
                                word_r <= {1'b0, word_r[19:1]};
                            if (step_r == 5'd23 && bitIdx_r == 5'(CMD_W - 1))
                            begin
                                tmr_r <= 10'd0;
                                state_r <= H_PULSE;
                            end
                        end
                    end
                end
                H_PULSE:
                begin
                    tmr_r <= tmr_r + 10'd1;
                    if (tmr_r == 10'(ERASE_PULSE_CYC - 1))
                    begin
                        clk_r <= 1'b0;
                        bitIdx_r <= bitIdx_r + 5'd1;
                        tmr_r <= 10'd0;
                        state_r <= H_DISCH;
                    end
                end
                H_DISCH:
                begin
                    tmr_r <= tmr_r + 10'd1;
                    if (tmr_r == 10'(DISCHARGE_CYC - 1))
                    begin
                        half_r <= 8'h00;
                        state_r <= H_SHIFT;
                    end
                end
                H_NEXT:
                begin
                    state_r <= H_LOAD;
                    step_r <= step_r + 5'd1;
                    if (step_r == 5'd23)
                    begin
                        rowPtr_r <= rowPtr_r + 16'h0001;
                        step_r <= 5'd16;
                        if (rows_r == 16'h0001)
                        begin
                            busy <= 1'b0;
                            done <= 1'b1;
                            state_r <= H_IDLE;
                        end
                        rows_r <= rows_r - 16'h0001;
                    end
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end

    assign link.progClk = clk_r;
    assign link.dataHostOut = word_r[0];
    assign link.dataHostOe = 1'b1;
endmodule : mre_host
`default_nettype wire

// [tb/mre_link_monitor.sv]
/*
 * Link checker for the row erase port: bit timing, frames, pulse and discharge.
 * Assumes progClk is divided from sys_clk by the host; watches the first link only.
 */
`timescale 1ns/10ps
`default_nettype none
module mre_link_monitor
    import mre_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic progClk,
    input wire logic dataHostOut,
    input wire logic dataHostOe,
    input wire logic dataDevOut,
    input wire logic dataDevOe,
    input wire logic progDataPin
);
    // any high phase longer than this is an erase pulse
    localparam int LONG_HI = 16;
    logic [15:0] hiCnt_r;
    logic [15:0] loCnt_r;
    logic [15:0] fallCnt_r;
    logic [22:0] bits_r;
    logic wasLong_r;
    logic longHi;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    assign longHi = hiCnt_r > LONG_HI;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hiCnt_r <= 16'h0000;
            loCnt_r <= 16'h0000;
        end
        else
        begin
            hiCnt_r <= progClk ? hiCnt_r + 16'h0001 : 16'h0000;
            loCnt_r <= progClk ? 16'h0000 : loCnt_r + 16'h0001;
        end
    end

    // bits taken at each fall, as the device takes them
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            fallCnt_r <= 16'h0000;
            bits_r <= 23'h00_0000;
            wasLong_r <= 1'b0;
        end
        else if (!progClk && $past(progClk))
        begin
            fallCnt_r <= fallCnt_r + 16'h0001;
            bits_r <= {bits_r[21:0], progDataPin};
            wasLong_r <= longHi;
        end
    end

    sequence s_eraseFall;
        $fell(progClk) ##0 longHi;
    endsequence

    sequence s_startThenNop;
        (bits_r[22:19] == 4'hF) ##0 (bits_r[2:0] == 3'h0) ##0 !progDataPin;
    endsequence

    chk_dev_quiet: assert property (!dataDevOe)
        else $error("device drives the data pin");
    chk_bit_stable: assert property (progClk && $past(progClk) |-> $stable(progDataPin))
        else $error("data moved while link clock high");
    chk_clk_min_hi: assert property ($rose(progClk) |=> progClk)
        else $error("link clock high phase too short");
    chk_pulse_len: assert property ($fell(progClk) |->
        (hiCnt_r <= LONG_HI || hiCnt_r >= ERASE_PULSE_CYC))
        else $error("erase pulse shorter than its time");
    chk_discharge_low: assert property ($rose(progClk) && wasLong_r |->
        loCnt_r >= DISCHARGE_CYC)
        else $error("discharge interval cut short");
    chk_data_low_pulse: assert property (progClk && longHi |-> !progDataPin)
        else $error("data not low during erase pulse");
    chk_frame_pos: assert property (s_eraseFall |-> fallCnt_r % 20 == 3)
        else $error("erase pulse not on fourth clock of a frame");
    chk_start_nop: assert property (s_eraseFall |-> s_startThenNop)
        else $error("erase pulse not after start command and nop");
endmodule : mre_link_monitor
`default_nettype wire

// [tb/test_multi_panel_row_erase_sequencer.sv]
/*
 * Bench: host and device on one link; a second device on a link driven here.
 * Assumes 125 MHz sys_clk; the second link clock runs only within frames.
 */
`timescale 1ns/10ps
`default_nettype none
module test_multi_panel_row_erase_sequencer;
    import mre_pkg::*;
    // memory control once the erase setup has run
    localparam logic [7:0] MEM_CTRL_ERASE =
        8'((1 << MC_PMSEL) | (1 << MC_ROWERASE) | (1 << MC_WPERMIT));
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [15:0] rowCount = 16'h0000;
    logic busy, done, erasePulse, multiPanelEn, eraseDone;
    logic [21:0] eraseRowAddr;
    logic [7:0] memCtrlState;
    logic ePulse2, mpEn2, eDone2;
    logic [21:0] eAddr2;
    logic [7:0] mCtrl2;
    int miscompares = 0;
    int nTests = 0;
    int cycles = 0;
    int n2 = 0;

    mre_link_if link();
    mre_link_if link2();
    mre_host u_mre_host (.sys_clk(sys_clk), .rst(rst), .link(link), .start(start),
        .rowCount(rowCount), .busy(busy), .done(done));
    mre_device u_mre_device (.sys_clk(sys_clk), .rst(rst), .link(link),
        .erasePulse(erasePulse), .eraseRowAddr(eraseRowAddr), .multiPanelEn(multiPanelEn),
        .memCtrlState(memCtrlState), .eraseDone(eraseDone));
    mre_device u_mre_device_2 (.sys_clk(sys_clk), .rst(rst), .link(link2),
        .erasePulse(ePulse2), .eraseRowAddr(eAddr2), .multiPanelEn(mpEn2),
        .memCtrlState(mCtrl2), .eraseDone(eDone2));
    mre_link_monitor u_mre_link_monitor (.sys_clk(sys_clk), .rst(rst),
        .progClk(link.progClk), .dataHostOut(link.dataHostOut), .dataHostOe(link.dataHostOe),
        .dataDevOut(link.dataDevOut), .dataDevOe(link.dataDevOe),
        .progDataPin(link.progDataPin));

    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    always @(posedge ePulse2) n2++;

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            miscompares++;
            $display("unexpected at %0t: run did not end", $time);
            finishTest();
        end
    end

    task automatic check(input logic ok, input string msg);
        nTests++;
        if (ok !== 1'b1)
        begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic finishTest;
        $display("comparisons %0d, mismatches %0d", nTests, miscompares);
        if (miscompares == 0 && nTests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finishTest

    // one frame on the second link, LSb first; bit 3 may be stretched
    task automatic send2(input logic [19:0] w, input int hold);
        for (int i = 0; i < 20; i++)
        begin
            link2.progClk = 1'b1;
            #3 link2.dataHostOut = w[i];
            #13;
            if (i == 3)
                #(hold);
            link2.progClk = 1'b0;
            #16;
            if (i == 3 && hold > 0)
                #(DISCHARGE_NS);
        end
    endtask : send2

    task automatic test_reset;
        check(multiPanelEn === 1'b0 && erasePulse === 1'b0, "mode or pulse at reset");
        check(memCtrlState === 8'h00 && busy === 1'b0, "state not cleared at reset");
        $display("test_reset done");
    endtask : test_reset

    task automatic run_rows(input logic [15:0] n, input bit refire);
        int k, nDone, w, hiLen;
        logic prev;
        k = 0;
        nDone = 0;
        w = 0;
        hiLen = 0;
        prev = 1'b0;
        @(negedge sys_clk);
        rowCount = n;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        while (done !== 1'b1 && w < 40000)
        begin
            @(negedge sys_clk);
            w++;
            // a second start while busy must not add rows
            start = refire && k == 1 && erasePulse && hiLen == 3;
            hiLen = erasePulse ? hiLen + 1 : hiLen;
            if (erasePulse === 1'b1 && !prev)
            begin
                check(eraseRowAddr === 22'(k * ROW_BYTES), "row address");
                check(multiPanelEn === 1'b1, "multi-panel mode off");
                check(memCtrlState === MEM_CTRL_ERASE, "memory control bits");
                k++;
            end
            if (erasePulse === 1'b0 && prev)
            begin
                check(hiLen >= ERASE_PULSE_CYC - 2 && hiLen <= ERASE_PULSE_CYC + 3,
                    "erase pulse length");
                hiLen = 0;
            end
            nDone = eraseDone === 1'b1 ? nDone + 1 : nDone;
            prev = erasePulse;
        end
        check(w < 40000 && k == int'(n) && nDone == int'(n), "row or done count");
        @(negedge sys_clk);
        check(busy === 1'b0 && erasePulse === 1'b0, "busy after done");
        $display("run_rows %0d done", n);
    endtask : run_rows

    task automatic test_zero;
        @(negedge sys_clk);
        rowCount = 16'h0000;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        repeat (20) @(negedge sys_clk);
        check(busy === 1'b0 && erasePulse === 1'b0, "zero rows started");
        $display("test_zero done");
    endtask : test_zero

    task automatic test_order;
        logic [19:0] cfg[9] = '{{OP_SET_WPERMIT, CMD_CORE}, {16'h0E02, CMD_CORE},
            {16'h6EF7, CMD_CORE}, {16'h0E3C, CMD_CORE}, {16'h6EF8, CMD_CORE},
            {16'h0E00, CMD_CORE}, {16'h6EF7, CMD_CORE},
            {16'h0E06, CMD_CORE}, {16'h6EF6, CMD_CORE}};
        send2({OP_SET_PMSEL, CMD_CORE}, 0);
        send2({OP_SET_ROWERASE, CMD_CORE}, 0);
        // start without write permit must not erase
        send2({16'hA5C3, CMD_TWRITE_START}, 0);
        send2({OP_NOP, CMD_CORE}, ERASE_PULSE_NS);
        #(DISCHARGE_NS);
        check(n2 == 0, "erase without write permit");
        for (int i = 0; i < 3; i++)
            send2(cfg[i], 0);
        send2({16'h5A3C, CMD_TWRITE_START}, 0);
        send2({OP_NOP, CMD_CORE}, ERASE_PULSE_NS);
        #(DISCHARGE_NS);
        check(n2 == 1 && eAddr2 === 22'h00_0200, "erase at loaded pointer");
        check(mpEn2 === 1'b0 && mCtrl2 === MEM_CTRL_ERASE, "mode or control bits");
        for (int i = 3; i < 9; i++)
            send2(cfg[i], 0);
        send2({16'h0040, CMD_TWRITE}, 0);
        repeat (6) @(negedge sys_clk);
        check(mpEn2 === 1'b1, "programming control not written");
        $display("test_order done");
    endtask : test_order

    initial
    begin
        link2.progClk = 1'b0;
        link2.dataHostOut = 1'b0;
        link2.dataHostOe = 1'b1;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        repeat (2) @(negedge sys_clk);
        test_reset();
        run_rows(16'h0003, 1'b0);
        run_rows(16'h0002, 1'b1);
        test_zero();
        #5 test_order();
        finishTest();
    end
endmodule : test_multi_panel_row_erase_sequencer
`default_nettype wire
